// *** inc/proximity_readout_i2c_defs.vh ***
// constants for the proximity readout i2c target
`ifndef PROXIMITY_READOUT_I2C_DEFS_VH
`define PROXIMITY_READOUT_I2C_DEFS_VH
`define ADDR_PRIMARY     7'h60
`define ADDR_ALTERNATE   7'h51
`define CMD_CONTROL      8'h03
`define CMD_PROX_COUNT   8'hf8
`define CMD_EVENT_FLAGS  8'hf9
`define CMD_IDENTITY     8'hfa
`define CTL_FORCE_BIT    0
`define CTL_AUTO_BIT     1
`define FLAG_DONE_BIT    0
`define IT_SETTING_RST   8'h01
`define CLOCK_KHZ        10000
`define AMBIENT_NS       278600
`define AMBIENT_CYCLES   ((`AMBIENT_NS / 100 * `CLOCK_KHZ + 9999) / 10000)
`define IT_STEP_NS       25000
`define IT_STEP_CYCLES   ((`IT_STEP_NS * `CLOCK_KHZ + 999999) / 1000000)
`endif

// *** rtl/proximity_readout_i2c.v ***
// proximity readout: i2c target, measurement sequencer and readout registers
//
// Contract
// - each completed measurement loads a new 16-bit proximity count from 0 to 65535.
// - the proximity count reads over i2c as low byte first, then high byte.
// - command code 0xfa returns a read-only identity word, fixed low byte, variant high byte.
// - the target answers at 0x60 or 0x51 by pin strap and the identity high byte tells which.
// - a read is address+w, command, repeated start, address+r, host acks low and nacks high.
// - the target drives acknowledge after its own address and every command and written data byte.
// - one measurement ends within the ambient phase plus twice the integration time.
// - an ambient phase of 278.6 us precedes the emitter and its level is subtracted.
// - reading the event flag register clears the latched event flags.
`include "proximity_readout_i2c_defs.vh"
module proximity_readout_i2c #(
  parameter [7:0]  ID_LOW       = 8'h5a, // arbitrary part code
  parameter [7:0]  ID_HIGH_PRI  = 8'h01, // arbitrary variant code, primary address
  parameter [7:0]  ID_HIGH_ALT  = 8'h02, // arbitrary variant code, alternate address
  parameter [23:0] AMB_CYCLES   = `AMBIENT_CYCLES,
  parameter [23:0] IT_STEP      = `IT_STEP_CYCLES
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        addr_alt_sel,
  input  wire [15:0] ambient_level,
  input  wire [15:0] reflected_level,
  output reg         light_emitter,
  output reg         ambient_offset_phase,
  output reg  [15:0] proximity_count,
  output reg         measuring
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_RX   = 7'h08;
  localparam [6:0] ST_RACK = 7'h10;
  localparam [6:0] ST_TX   = 7'h20;
  localparam [6:0] ST_MACK = 7'h40;
  localparam [2:0] M_IDLE  = 3'h1;
  localparam [2:0] M_AMB   = 3'h2;
  localparam [2:0] M_INT   = 3'h4;

  // three-stage pin sync, a change counts once stages two and three agree
  reg  [2:0] scl_s_r, sda_s_r, sel_s_r;
  reg        scl_r, sda_r, sel_r;
  always @(posedge clock) begin
    if (rst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      sel_s_r <= 3'h0;
      scl_r   <= 1'b1;
      sda_r   <= 1'b1;
      sel_r   <= 1'b0;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      sel_s_r <= {sel_s_r[1:0], addr_alt_sel};
      if (scl_s_r[2] == scl_s_r[1]) scl_r <= scl_s_r[2];
      if (sda_s_r[2] == sda_s_r[1]) sda_r <= sda_s_r[2];
      if (sel_s_r[2] == sel_s_r[1]) sel_r <= sel_s_r[2];
    end
  end
  wire scl_nxt   = (scl_s_r[2] == scl_s_r[1]) ? scl_s_r[2] : scl_r;
  wire sda_nxt   = (sda_s_r[2] == sda_s_r[1]) ? sda_s_r[2] : sda_r;
  wire scl_rise  = scl_nxt & ~scl_r;
  wire scl_fall  = ~scl_nxt & scl_r;
  // only the host makes these; the target just watches for them
  wire start_det = scl_r & scl_nxt & sda_r & ~sda_nxt;
  wire stop_det  = scl_r & scl_nxt & ~sda_r & sda_nxt;
  wire [6:0] own_addr = sel_r ? `ADDR_ALTERNATE : `ADDR_PRIMARY;

  reg  [6:0]  st_r;
  reg  [3:0]  bit_cnt_r;
  reg  [7:0]  shift_r;
  reg         rw_r;
  reg  [1:0]  rx_idx_r;
  reg         tx_idx_r;
  reg  [7:0]  cmd_r;
  reg  [7:0]  wr_low_r;
  reg  [15:0] snap_r;
  reg  [7:0]  it_setting_r;
  reg         auto_r;
  reg         force_r;
  reg  [7:0]  flags_r;
  reg         done_pulse_r;

  function [15:0] read_word;
    input [7:0] cmd;
    begin
      case (cmd)
        `CMD_PROX_COUNT:  read_word = proximity_count;
        `CMD_EVENT_FLAGS: read_word = {8'h00, flags_r};
        `CMD_IDENTITY:    read_word = {sel_r ? ID_HIGH_ALT : ID_HIGH_PRI, ID_LOW};
        `CMD_CONTROL:     read_word = {6'h00, auto_r, 1'b0, it_setting_r};
        default:          read_word = 16'h0000;
      endcase
    end
  endfunction

  wire addr_hit  = (shift_r[7:1] == own_addr);
  wire flag_read = (st_r == ST_AACK) & scl_fall & rw_r & (cmd_r == `CMD_EVENT_FLAGS);

  always @(posedge clock) begin
    if (rst) begin
      st_r         <= ST_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      rw_r         <= 1'b0;
      rx_idx_r     <= 2'h0;
      tx_idx_r     <= 1'b0;
      cmd_r        <= 8'h00;
      wr_low_r     <= 8'h00;
      snap_r       <= 16'h0000;
      it_setting_r <= `IT_SETTING_RST;
      auto_r       <= 1'b0;
      force_r      <= 1'b0;
      sda_out      <= 1'b0;
      sda_oe       <= 1'b0;
    end else begin
      force_r <= 1'b0;
      if (start_det) begin
        // a repeated start keeps the command code for the read phase
        st_r      <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (stop_det) begin
        st_r   <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_r)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (st_r == ST_ADDR) begin
                if (addr_hit) begin
                  st_r     <= ST_AACK;
                  sda_oe   <= 1'b1;
                  rw_r     <= shift_r[0];
                  rx_idx_r <= 2'h0;
                  tx_idx_r <= 1'b0;
                  // count captured once per read so both bytes match
                  snap_r   <= read_word(cmd_r);
                end else begin
                  st_r <= ST_IDLE;
                end
              end else begin
                st_r   <= ST_RACK;
                sda_oe <= 1'b1;
                case (rx_idx_r)
                  2'h0: cmd_r <= shift_r;
                  2'h1: wr_low_r <= shift_r;
                  2'h2: begin
                    if (cmd_r == `CMD_CONTROL) begin
                      it_setting_r <= (wr_low_r == 8'h00) ? 8'h01 : wr_low_r;
                      auto_r       <= shift_r[`CTL_AUTO_BIT];
                      force_r      <= shift_r[`CTL_FORCE_BIT];
                    end
                  end
                  // bytes past the high byte are acked and dropped
                  default: ;
                endcase
                if (rx_idx_r != 2'h3) rx_idx_r <= rx_idx_r + 2'h1;
              end
            end
          end
          ST_AACK, ST_RACK: begin
            if (scl_fall) begin
              if (st_r == ST_AACK && rw_r) begin
                st_r    <= ST_TX;
                shift_r <= {snap_r[6:0], 1'b0};
                sda_oe  <= ~snap_r[7];
              end else begin
                st_r   <= ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                bit_cnt_r <= 4'h0;
                st_r      <= ST_MACK;
                sda_oe    <= 1'b0;
              end else begin
                sda_oe  <= ~shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // host nack ends the read
              if (sda_r) begin
                st_r <= ST_IDLE;
              end else begin
                tx_idx_r <= ~tx_idx_r;
                shift_r  <= tx_idx_r ? snap_r[7:0] : snap_r[15:8];
              end
            end else if (scl_fall) begin
              st_r    <= ST_TX;
              sda_oe  <= ~shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
          default: begin
            st_r   <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // latched events; a new event in the clearing cycle wins over the clear
  always @(posedge clock) begin
    if (rst) begin
      flags_r <= 8'h00;
    end else begin
      if (flag_read) flags_r <= 8'h00;
      if (done_pulse_r) flags_r[`FLAG_DONE_BIT] <= 1'b1;
    end
  end

  // measurement sequencer: ambient phase, then emitter for twice the integration time
  reg [2:0]  m_st_r;
  reg [23:0] m_cnt_r;
  reg [15:0] amb_r;
  wire [23:0] int_cycles = {7'h00, it_setting_r, 1'b0} * IT_STEP;
  wire [16:0] diff = {1'b0, reflected_level} - {1'b0, amb_r};
  always @(posedge clock) begin
    if (rst) begin
      m_st_r               <= M_IDLE;
      m_cnt_r              <= 24'h000000;
      amb_r                <= 16'h0000;
      proximity_count      <= 16'h0000;
      light_emitter        <= 1'b0;
      ambient_offset_phase <= 1'b0;
      measuring            <= 1'b0;
      done_pulse_r         <= 1'b0;
    end else begin
      done_pulse_r <= 1'b0;
      case (m_st_r)
        M_IDLE: begin
          if (force_r || auto_r) begin
            m_st_r               <= M_AMB;
            m_cnt_r              <= AMB_CYCLES - 24'h000001;
            ambient_offset_phase <= 1'b1;
            measuring            <= 1'b1;
          end
        end
        M_AMB: begin
          if (m_cnt_r == 24'h000000) begin
            amb_r                <= ambient_level;
            ambient_offset_phase <= 1'b0;
            light_emitter        <= 1'b1;
            m_st_r               <= M_INT;
            m_cnt_r              <= int_cycles - 24'h000001;
          end else begin
            m_cnt_r <= m_cnt_r - 24'h000001;
          end
        end
        M_INT: begin
          if (m_cnt_r == 24'h000000) begin
            // background subtracted, clamped at zero
            proximity_count <= diff[16] ? 16'h0000 : diff[15:0];
            light_emitter   <= 1'b0;
            measuring       <= 1'b0;
            done_pulse_r    <= 1'b1;
            m_st_r          <= M_IDLE;
          end else begin
            m_cnt_r <= m_cnt_r - 24'h000001;
          end
        end
        default: begin
          m_st_r <= M_IDLE;
        end
      endcase
    end
  end
endmodule

// *** testbench/i2c_host_model.sv ***
// i2c controller standing in for the host
module i2c_host_model (
  input  wire  clock,
  input  wire  sda,
  output logic scl = 1'b1,
  output logic host_oe = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // ten clocks a phase leaves room for the target's input synchroniser
  task automatic ph(input logic s, input logic o);
    scl <= s;
    host_oe <= o;
    repeat (10) @(posedge clock);
  endtask
  task automatic start;
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask
  task automatic stop;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // nine bits msb first; a 1 releases the line so the target can answer
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, !tx[i]);
      ph(1'b1, !tx[i]);
      rx[i] = sda;
      ph(1'b0, !tx[i]);
    end
  endtask
endmodule

// *** testbench/proximity_readout_i2c_properties.sv ***
// port checks for the proximity readout target
module proximity_readout_i2c_properties #(
  parameter [23:0] AMB_CYCLES = 24'd2786,
  parameter [23:0] IT_STEP    = 24'd250
) (
  input wire        clock,
  input wire        rst,
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        addr_alt_sel,
  input wire [15:0] ambient_level,
  input wire [15:0] reflected_level,
  input wire        light_emitter,
  input wire        ambient_offset_phase,
  input wire [15:0] proximity_count,
  input wire        measuring
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  localparam int MAXM = AMB_CYCLES + 2 * IT_STEP * 255 + 8;
  logic [31:0] amb_n = 0;
  logic [31:0] em_n = 0;
  logic [31:0] meas_n = 0;
  wire  [15:0] diff = (reflected_level > ambient_level) ? reflected_level - ambient_level : 16'h0;
  always @(posedge clock) begin
    amb_n <= (rst || !ambient_offset_phase) ? 32'h0 : amb_n + 32'h1;
    em_n <= (rst || !light_emitter) ? 32'h0 : em_n + 32'h1;
    meas_n <= (rst || !measuring) ? 32'h0 : meas_n + 32'h1;
  end
  a_sda_never_high: assert property (sda_out == 1'b0) else $error("sda driven high");
  // the target may only move sda while scl is low, or it would frame the bus
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved");
  a_start_amb: assert property ($rose(measuring) |-> ##[0:2] ambient_offset_phase)
    else $error("no ambient phase");
  a_amb_first: assert property ($rose(light_emitter) |-> $past(ambient_offset_phase))
    else $error("emitter before ambient");
  a_amb_length: assert property ($fell(ambient_offset_phase) |-> amb_n == AMB_CYCLES)
    else $error("ambient length");
  a_emit_length: assert property ($fell(light_emitter) |-> em_n != 0 && em_n % (2 * IT_STEP) == 0)
    else $error("emitter length");
  a_meas_budget: assert property (meas_n <= MAXM) else $error("measurement too long");
  a_count_load: assert property ($fell(measuring) |-> ##[0:1] proximity_count == diff)
    else $error("count value");
endmodule
bind proximity_readout_i2c proximity_readout_i2c_properties #(.AMB_CYCLES(AMB_CYCLES),
  .IT_STEP(IT_STEP)) i_props (.clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_alt_sel(addr_alt_sel),
  .ambient_level(ambient_level), .reflected_level(reflected_level),
  .light_emitter(light_emitter), .ambient_offset_phase(ambient_offset_phase),
  .proximity_count(proximity_count), .measuring(measuring));

// *** testbench/proximity_readout_i2c_test.sv ***
// self-checking bench for the proximity readout target
`include "proximity_readout_i2c_defs.vh"
module proximity_readout_i2c_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0;
  logic        rst = 1;
  logic        alt = 0;
  logic [15:0] amb = 16'h0100;
  logic [15:0] refl = 16'h0350;
  wire         scl, host_oe, sda_out, sda_oe, emit, phase, meas;
  wire  [15:0] count;
  wire         sda = !(sda_oe | host_oe);
  int          bad_count = 0;
  int          checks_done = 0;
  int          len = 0;
  int          base = 0;
  logic        wobble = 0;
  logic        meas_q = 0;
  logic        flip = 0;
  wire  [15:0] refl_in = refl ^ (flip ? 16'h1110 : 16'h0000);
  logic [15:0] w;
  logic [8:0]  r;
  initial forever #50 clock = ~clock;
  always @(posedge clock) if (meas) len <= len + 1;
  // while wobble is set the front end flips once per finished measurement, never while one is sampled
  always @(posedge clock) begin
    meas_q <= meas;
    if (meas_q && !meas) flip <= wobble ? ~flip : 1'b0;
  end
  proximity_readout_i2c #(.AMB_CYCLES(24'd10), .IT_STEP(24'd2)) i_dut (.clock(clock),
    .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_alt_sel(alt), .ambient_level(amb), .reflected_level(refl_in), .light_emitter(emit),
    .ambient_offset_phase(phase), .proximity_count(count), .measuring(meas));
  i2c_host_model i_host (.clock(clock), .sda(sda), .scl(scl), .host_oe(host_oe));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [8:0] a0, a1, a2, a3;
    i_host.start;
    i_host.xfer({`ADDR_PRIMARY, 2'b01}, a0);
    i_host.xfer({c, 1'b1}, a1);
    i_host.xfer({d[7:0], 1'b1}, a2);
    i_host.xfer({d[15:8], 1'b1}, a3);
    i_host.stop;
    check("write acks", {12'h0, a0[0], a1[0], a2[0], a3[0]}, 16'h0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] v);
    logic [8:0] a0, a1, a2, b0, b1;
    i_host.start;
    i_host.xfer({a, 2'b01}, a0);
    i_host.xfer({c, 1'b1}, a1);
    i_host.start;
    i_host.xfer({a, 2'b11}, a2);
    i_host.xfer(9'h1fe, b0);
    i_host.xfer(9'h1ff, b1);
    i_host.stop;
    v = {b1[8:1], b0[8:1]};
    check("read acks", {13'h0, a0[0], a1[0], a2[0]}, 16'h0);
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    repeat (6) @(posedge clock);
    rd(`ADDR_PRIMARY, `CMD_IDENTITY, w);
    check("identity", w, 16'h015a);
    i_host.start;
    i_host.xfer({`ADDR_ALTERNATE, 2'b01}, r);
    i_host.stop;
    check("foreign address ack", {15'h0, r[0]}, 16'h0001);
    $display("test identity done");
    // second pass drives the subtraction below zero
    for (int t = 0; t < 2; t++) begin
      refl <= t ? 16'h0050 : 16'h0350;
      base = len;
      wr(`CMD_CONTROL, 16'h0101);
      repeat (20) @(posedge clock);
      // 1.2 x (10 + 2 x 1 x 2) cycles
      check("duration", {15'h0, len - base >= 14 && len - base <= 17}, 16'h0001);
      rd(`ADDR_PRIMARY, `CMD_PROX_COUNT, w);
      check("count", w, t ? 16'h0000 : 16'h0250);
      rd(`ADDR_PRIMARY, `CMD_EVENT_FLAGS, w);
      check("flags set", w, 16'h0001);
      rd(`ADDR_PRIMARY, `CMD_EVENT_FLAGS, w);
      check("flags cleared", w, 16'h0000);
    end
    $display("test measurement done");
    // continuous mode while the count keeps changing: both bytes must be one word
    refl   <= 16'h0350;
    wobble <= 1'b1;
    wr(`CMD_CONTROL, 16'h0203);
    rd(`ADDR_PRIMARY, `CMD_PROX_COUNT, w);
    check("count word", {15'h0, w == 16'h0250 || w == 16'h1140}, 16'h0001);
    rd(`ADDR_PRIMARY, `CMD_CONTROL, w);
    check("control auto", w, 16'h0203);
    wobble <= 1'b0;
    wr(`CMD_CONTROL, 16'h0000);
    rd(`ADDR_PRIMARY, `CMD_CONTROL, w);
    check("control idle", w, 16'h0001);
    $display("test auto done");
    alt <= 1;
    repeat (10) @(posedge clock);
    rd(`ADDR_ALTERNATE, `CMD_IDENTITY, w);
    check("alternate identity", w, 16'h025a);
    $display("test strap done");
    print_verdict;
  end
endmodule
